// File: shared/isa_consts.vh
/*
  Constants for the I2C slave address/handshake block: APB register offsets,
  field positions, reset values, mode codes and fsm state codes.
  Assumes inclusion by bare name from the design files under verilog/.
*/
`ifndef ISA_CONSTS_VH
`define ISA_CONSTS_VH

// register byte offsets
`define ISA_OFF_CTRL 8'h00
`define ISA_OFF_STAT 8'h04
`define ISA_OFF_ADDR 8'h08
`define ISA_OFF_DATA 8'h0c
`define ISA_OFF_IRQS 8'h10
`define ISA_OFF_IRQM 8'h14

// control register fields
`define ISA_CTRL_MODE_HI 7
`define ISA_CTRL_MODE_LO 5
`define ISA_CTRL_EN 1
`define ISA_MODE_I2C 3'h6

// control/status register fields
`define ISA_ST_BYTE_DONE 7
`define ISA_ST_MATCHED 6
`define ISA_ST_BUSY 5
`define ISA_ST_TX_SEL 4
`define ISA_ST_TX_ACK 3
`define ISA_ST_READ_REQ 2
`define ISA_ST_WAKE_EN 1
`define ISA_ST_RX_ACK 0
`define ISA_ST_RESET 8'h01

// interrupt status/mask fields
`define ISA_IRQ_ADDR 0
`define ISA_IRQ_BYTE 1
`define ISA_IRQ_STOP 2
`define ISA_IRQ_W 3

// reset values
`define ISA_CTRL_RESET 8'h00
`define ISA_ADDR_RESET 7'h00

// fsm states
`define ISA_S_IDLE 3'h0
`define ISA_S_ADDR 3'h1
`define ISA_S_AACK 3'h2
`define ISA_S_WAIT 3'h3
`define ISA_S_RX 3'h4
`define ISA_S_RACK 3'h5
`define ISA_S_TX 3'h6
`define ISA_S_TACK 3'h7

`endif

// File: verilog/isa_sync2.v
/*
  Two flip-flop synchroniser for a bus of level inputs.
  Assumes inputs are asynchronous to clk_i; the output is safe to use.
*/
`timescale 1ns/10ps
`default_nettype none

module isa_sync2 #(
  parameter W = 2,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  // clock and reset
  input wire clk_i,
  input wire srst_i,
  // async in, sync out
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);

  reg [W-1:0] meta_r;

  // first stage read only by the second
  always @(posedge clk_i) begin
    if (srst_i) begin
      meta_r <= INIT;
      q_o <= INIT;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule

`default_nettype wire

// File: verilog/isa_bus_cond.v
/*
  Bus condition detector: START, STOP and SCL edges from synchronised lines.
  Assumes scl_i/sda_i already pass a synchroniser on clk_i.
*/
`timescale 1ns/10ps
`default_nettype none

module isa_bus_cond (
  // clock and reset
  input wire clk_i,
  input wire srst_i,
  // synchronised bus lines
  input wire scl_i,
  input wire sda_i,
  // one-cycle condition pulses
  output wire start_o,
  output wire stop_o,
  output wire scl_rise_o,
  output wire scl_fall_o
);

  reg scl_q_r;
  reg sda_q_r;

  // previous levels, idle bus is high
  always @(posedge clk_i) begin
    if (srst_i) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
    end
  end

  // sda fall with scl high both samples
  assign start_o = scl_q_r & scl_i & sda_q_r & ~sda_i;
  assign stop_o = scl_q_r & scl_i & ~sda_q_r & sda_i;
  assign scl_rise_o = ~scl_q_r & scl_i;
  assign scl_fall_o = scl_q_r & ~scl_i;

endmodule

`default_nettype wire

// File: verilog/isa_slave.v
/*
  I2C slave address and handshake engine with an APB register slave.
  Assumes an external I2C master on SCL/SDA (open drain, pulled up outside),
  an APB master on CLK_I, and a low-power level from the clock controller.
*/
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "isa_consts.vh"
`default_nettype none

module isa_slave (
  // clock and reset
  input wire CLK_I,
  input wire SRST_I,
  // apb slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  // i2c pins, open drain
  input wire SCL_I,
  output reg SCL_O,
  output reg SCL_OE_O,
  input wire SDA_I,
  output reg SDA_O,
  output reg SDA_OE_O,
  // system
  input wire LOWPWR_I,
  output reg IRQ_O,
  output reg WAKE_O
);

  wire scl_s;
  wire sda_s;
  wire start_p;
  wire stop_p;
  wire scl_rise;
  wire scl_fall;

  // pins pass two flops before any logic
  isa_sync2 #(.W(2), .INIT(2'h3)) u_sync (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .d_i({SCL_I, SDA_I}),
    .q_o({scl_s, sda_s})
  );

  isa_bus_cond u_cond (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .scl_i(scl_s),
    .sda_i(sda_s),
    .start_o(start_p),
    .stop_o(stop_p),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall)
  );

  // software-owned configuration and the engine-set interrupt status
  reg [7:0] ctrl_r;
  reg [6:0] own_addr_r;
  reg tx_sel_r;
  reg tx_ack_level_r;
  reg wake_en_r;
  reg [`ISA_IRQ_W-1:0] irq_mask_r;
  reg [`ISA_IRQ_W-1:0] irq_sts_r;
  // engine state
  reg [2:0] state_r;
  reg [3:0] cnt_r;
  reg [7:0] sh_r;
  reg [7:0] rx_data_r;
  reg busy_r;
  reg matched_r;
  reg read_req_r;
  reg rx_ack_r;
  reg byte_done_r;
  reg ev_addr_r;
  reg ev_byte_r;
  reg ev_stop_r;
  // apb decode
  wire acc_set;
  wire acc_done;
  wire wr_done;
  wire rd_done;
  wire hit;
  wire data_wr;
  wire data_rd;
  wire active;
  reg [7:0] rd_val;
  reg [7:0] stat_val;

  // engine runs only in i2c mode with the interface enabled
  assign active = ctrl_r[`ISA_CTRL_EN] &&
    (ctrl_r[`ISA_CTRL_MODE_HI:`ISA_CTRL_MODE_LO] == `ISA_MODE_I2C);

  // setup plus one wait cycle; effect lands at the pready edge
  assign acc_set = PSEL_I & PENABLE_I & ~PREADY_O;
  assign acc_done = PSEL_I & PENABLE_I & PREADY_O;
  assign wr_done = acc_done & PWRITE_I & ~PSLVERR_O;
  assign rd_done = acc_done & ~PWRITE_I & ~PSLVERR_O;
  assign data_wr = wr_done && (PADDR_I == `ISA_OFF_DATA);
  assign data_rd = rd_done && (PADDR_I == `ISA_OFF_DATA);
  assign hit = (PADDR_I == `ISA_OFF_CTRL) || (PADDR_I == `ISA_OFF_STAT) ||
    (PADDR_I == `ISA_OFF_ADDR) || (PADDR_I == `ISA_OFF_DATA) ||
    (PADDR_I == `ISA_OFF_IRQS) || (PADDR_I == `ISA_OFF_IRQM);

  // status byte as software sees it
  always @* begin
    stat_val = 8'h00;
    stat_val[`ISA_ST_BYTE_DONE] = byte_done_r;
    stat_val[`ISA_ST_MATCHED] = matched_r;
    stat_val[`ISA_ST_BUSY] = busy_r;
    stat_val[`ISA_ST_TX_SEL] = tx_sel_r;
    stat_val[`ISA_ST_TX_ACK] = tx_ack_level_r;
    stat_val[`ISA_ST_READ_REQ] = read_req_r;
    stat_val[`ISA_ST_WAKE_EN] = wake_en_r;
    stat_val[`ISA_ST_RX_ACK] = rx_ack_r;
  end

  // read mux, unused upper bits read zero
  always @* begin
    case (PADDR_I)
      `ISA_OFF_CTRL: rd_val = ctrl_r;
      `ISA_OFF_STAT: rd_val = stat_val;
      `ISA_OFF_ADDR: rd_val = {1'b0, own_addr_r};
      `ISA_OFF_DATA: rd_val = rx_data_r;
      `ISA_OFF_IRQS: rd_val = {5'h00, irq_sts_r};
      `ISA_OFF_IRQM: rd_val = {5'h00, irq_mask_r};
      default: rd_val = 8'h00;
    endcase
  end

  // apb handshake, answer registered one cycle into access
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
    end else begin
      PREADY_O <= acc_set;
      if (acc_set) begin
        PSLVERR_O <= ~hit;
        PRDATA_O <= {24'h000000, rd_val};
      end else begin
        PSLVERR_O <= 1'b0;
      end
    end
  end

  // configuration writes
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      ctrl_r <= `ISA_CTRL_RESET;
      own_addr_r <= `ISA_ADDR_RESET;
      tx_sel_r <= 1'b0;
      tx_ack_level_r <= 1'b0;
      wake_en_r <= 1'b0;
      irq_mask_r <= {`ISA_IRQ_W{1'b0}};
    end else if (wr_done) begin
      case (PADDR_I)
        `ISA_OFF_CTRL: ctrl_r <= PWDATA_I[7:0];
        `ISA_OFF_ADDR: own_addr_r <= PWDATA_I[6:0];
        `ISA_OFF_STAT: begin
          tx_sel_r <= PWDATA_I[`ISA_ST_TX_SEL];
          tx_ack_level_r <= PWDATA_I[`ISA_ST_TX_ACK];
          // stays set until software clears it
          wake_en_r <= PWDATA_I[`ISA_ST_WAKE_EN];
        end
        `ISA_OFF_IRQM: irq_mask_r <= PWDATA_I[`ISA_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky sources, write one to clear; a new event wins over the clear
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      irq_sts_r <= {`ISA_IRQ_W{1'b0}};
    end else begin
      if (wr_done && (PADDR_I == `ISA_OFF_IRQS)) begin
        irq_sts_r <= (irq_sts_r & ~PWDATA_I[`ISA_IRQ_W-1:0]) |
          {ev_stop_r, ev_byte_r, ev_addr_r};
      end else begin
        irq_sts_r <= irq_sts_r | {ev_stop_r, ev_byte_r, ev_addr_r};
      end
    end
  end

  // single interrupt line, masked per source
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      IRQ_O <= 1'b0;
      WAKE_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_sts_r & irq_mask_r);
      // wake request holds until the low-power level drops
      if (!LOWPWR_I)
        WAKE_O <= 1'b0;
      else if (ev_addr_r && wake_en_r)
        WAKE_O <= 1'b1;
    end
  end

  // open-drain levels are always low; only the enables move
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      SCL_O <= 1'b0;
      SDA_O <= 1'b0;
    end else begin
      SCL_O <= 1'b0;
      SDA_O <= 1'b0;
    end
  end

  // protocol engine; never pulls sda low while scl is high outside an ack
  // or data bit, so it cannot create a START of its own
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      state_r <= `ISA_S_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      rx_data_r <= 8'h00;
      busy_r <= 1'b0;
      matched_r <= 1'b0;
      read_req_r <= 1'b0;
      rx_ack_r <= 1'b1;
      byte_done_r <= 1'b0;
      ev_addr_r <= 1'b0;
      ev_byte_r <= 1'b0;
      ev_stop_r <= 1'b0;
      SCL_OE_O <= 1'b0;
      SDA_OE_O <= 1'b0;
    end else begin
      ev_addr_r <= 1'b0;
      ev_byte_r <= 1'b0;
      ev_stop_r <= 1'b0;
      // data access clears byte done unless a byte completes now
      if (data_wr || data_rd)
        byte_done_r <= 1'b0;
      if (!active) begin
        state_r <= `ISA_S_IDLE;
        busy_r <= 1'b0;
        SCL_OE_O <= 1'b0;
        SDA_OE_O <= 1'b0;
      end else if (start_p) begin
        // also a repeated start; busy regardless of later match
        busy_r <= 1'b1;
        matched_r <= 1'b0;
        state_r <= `ISA_S_ADDR;
        cnt_r <= 4'h0;
        SCL_OE_O <= 1'b0;
        SDA_OE_O <= 1'b0;
      end else if (stop_p) begin
        busy_r <= 1'b0;
        ev_stop_r <= 1'b1;
        state_r <= `ISA_S_IDLE;
        SCL_OE_O <= 1'b0;
        SDA_OE_O <= 1'b0;
      end else begin
        case (state_r)
          `ISA_S_ADDR: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == 4'h7) begin
                cnt_r <= 4'h0;
                if (sh_r[6:0] == own_addr_r) begin
                  matched_r <= 1'b1;
                  ev_addr_r <= 1'b1;
                  read_req_r <= sda_s;
                  state_r <= `ISA_S_AACK;
                end else begin
                  state_r <= `ISA_S_IDLE;
                end
              end
            end
          end
          `ISA_S_AACK: begin
            if (scl_fall) begin
              if (cnt_r == 4'h0) begin
                SDA_OE_O <= 1'b1;
                cnt_r <= 4'h1;
              end else begin
                SDA_OE_O <= 1'b0;
                SCL_OE_O <= 1'b1;
                state_r <= `ISA_S_WAIT;
              end
            end
          end
          `ISA_S_WAIT: begin
            // software picks direction from read request via tx select
            if (tx_sel_r && data_wr) begin
              SCL_OE_O <= 1'b0;
              sh_r <= PWDATA_I[7:0];
              SDA_OE_O <= ~PWDATA_I[7];
              cnt_r <= 4'h0;
              state_r <= `ISA_S_TX;
            end else if (!tx_sel_r && data_rd) begin
              SCL_OE_O <= 1'b0;
              cnt_r <= 4'h0;
              state_r <= `ISA_S_RX;
            end
          end
          `ISA_S_RX: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == 4'h7) begin
                rx_data_r <= {sh_r[6:0], sda_s};
                cnt_r <= 4'h0;
                state_r <= `ISA_S_RACK;
              end
            end
          end
          `ISA_S_RACK: begin
            if (scl_fall) begin
              if (cnt_r == 4'h0) begin
                SDA_OE_O <= ~tx_ack_level_r;
                cnt_r <= 4'h1;
                byte_done_r <= 1'b1;
                ev_byte_r <= 1'b1;
              end else begin
                SDA_OE_O <= 1'b0;
                SCL_OE_O <= 1'b1;
                state_r <= `ISA_S_WAIT;
              end
            end
          end
          `ISA_S_TX: begin
            if (scl_rise)
              cnt_r <= cnt_r + 4'h1;
            if (scl_fall) begin
              if (cnt_r == 4'h8) begin
                SDA_OE_O <= 1'b0;
                state_r <= `ISA_S_TACK;
              end else begin
                sh_r <= {sh_r[6:0], 1'b0};
                SDA_OE_O <= ~sh_r[6];
              end
            end
          end
          `ISA_S_TACK: begin
            if (scl_rise)
              rx_ack_r <= sda_s;
            if (scl_fall) begin
              byte_done_r <= 1'b1;
              ev_byte_r <= 1'b1;
              if (!rx_ack_r) begin
                SCL_OE_O <= 1'b1;
                state_r <= `ISA_S_WAIT;
              end else begin
                // sda stays released so the master can stop
                state_r <= `ISA_S_IDLE;
              end
            end
          end
          default: begin
            SCL_OE_O <= 1'b0;
            SDA_OE_O <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// File: testbench/isa_chk.sv
/* port checker for isa_slave: apb timing, stretch, drive, wake.
   assumes a bind from the bench top; scl and sda are wire levels. */
`timescale 1ns/10ps
`include "isa_consts.vh"
`default_nettype none
module isa_chk (
  // clock, reset, apb
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // pins and system
  input wire logic SCL_I,
  input wire logic SCL_O,
  input wire logic SCL_OE_O,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic LOWPWR_I,
  input wire logic IRQ_O,
  input wire logic WAKE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  // a completed data register access is what ends a stretch
  wire logic data_acc = PSEL_I && PENABLE_I && PREADY_O &&
    PADDR_I == `ISA_OFF_DATA;
  apb_wait_a: assert property (
    PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O) else $error("late ready");
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held");
  err_with_a: assert property (PSLVERR_O |-> PREADY_O)
    else $error("slverr alone");
  no_start_a: assert property (
    $rose(SDA_OE_O) |-> !$past(SCL_I)) else $error("sda fell, scl high");
  pins_low_a: assert property (!SCL_O && !SDA_O)
    else $error("pin driven high");
  stretch_hold_a: assert property (
    SCL_OE_O && !data_acc |=> SCL_OE_O) else $error("stretch dropped");
  stretch_begin_a: assert property (
    $rose(SCL_OE_O) |-> !SDA_OE_O && !$past(SCL_I)) else $error("bad stretch");
  irq_clear_a: assert property (
    $fell(IRQ_O) |-> $past(PWRITE_I && PREADY_O, 2)) else $error("irq fell");
  wake_cause_a: assert property (
    $rose(WAKE_O) |-> $past(LOWPWR_I)) else $error("wake while awake");
  wake_drop_a: assert property (!LOWPWR_I |=> !WAKE_O)
    else $error("wake held");
  cover property ($rose(SCL_OE_O));
  cover property ($rose(IRQ_O));
  cover property ($rose(WAKE_O));
endmodule
`default_nettype wire

// File: testbench/isa_mst.sv
/* behavioural i2c bus master, 320 ns scl period, open drain.
   assumes pulled-up wires; scl_i and sda_i are the resolved levels. */
`timescale 1ns/10ps
`default_nettype none
module isa_mst (
  // resolved wire levels
  input wire logic scl_i,
  input wire logic sda_i,
  // pulls, high pulls the wire low; hung_o flags a stretch timeout
  output var logic scl_oe_o,
  output var logic sda_oe_o,
  output var logic hung_o
);
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    hung_o = 1'b0;
  end
  // release scl, honour stretching, but never wait forever
  task automatic rise();
    int n;
    scl_oe_o = 1'b0;
    for (n = 0; n < 4000 && !scl_i; n++) #10;
    if (!scl_i) hung_o = 1'b1;
  endtask
  // start or repeated start, only ever from this side
  task automatic start();
    sda_oe_o = 1'b0;
    #60 rise();
    #120 sda_oe_o = 1'b1;
    #120 scl_oe_o = 1'b1;
    #80;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_oe_o = !b;
    #60 rise();
    // rise() spends one 10 ns step, so the bit takes 320 ns
    #110 r = sda_i;
    scl_oe_o = 1'b1;
    #140;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a,
      output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, r);
  endtask
  task automatic stop();
    sda_oe_o = 1'b1;
    #60 rise();
    #120 sda_oe_o = 1'b0;
    #200;
  endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
/* self-checking bench for isa_slave with apb tasks and a master model.
   assumes isa_chk and isa_mst are compiled first. */
`timescale 1ns/10ps
`include "isa_consts.vh"
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic lowpwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, scl_o, scl_oe, sda_o, sda_oe, irq, wake;
  logic m_scl_oe, m_sda_oe, m_hung, ack;
  logic [7:0] own, d0, d1, q;
  int n_errors = 0;
  int compares = 0;
  // pull-ups: a released wire reads high
  wire logic scl_w = (scl_oe ? scl_o : 1'b1) & !m_scl_oe;
  wire logic sda_w = (sda_oe ? sda_o : 1'b1) & !m_sda_oe;
  isa_slave u_dut (.CLK_I(clk), .SRST_I(srst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda_w),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .LOWPWR_I(lowpwr), .IRQ_O(irq),
    .WAKE_O(wake));
  isa_mst u_mst (.scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(m_scl_oe),
    .sda_oe_o(m_sda_oe), .hung_o(m_hung));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic close_out();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer plus an idle cycle, so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    // realign first: callers may return from the link model off the edge
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
    if (n == 50) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, e, rd);
  endtask
  // status byte expected from the flags that the rules set
  function automatic logic [31:0] stat_exp(input logic m, b, r, w, a);
    stat_exp = 32'h0;
    stat_exp[`ISA_ST_MATCHED] = m;
    stat_exp[`ISA_ST_BUSY] = b;
    stat_exp[`ISA_ST_READ_REQ] = r;
    stat_exp[`ISA_ST_WAKE_EN] = w;
    stat_exp[`ISA_ST_RX_ACK] = a;
  endfunction
  // one edge first: the line lags its status by a cycle after a clear
  task automatic wait_irq();
    int n;
    @(posedge clk);
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
    if (n == 3000) begin
      n_errors++;
      close_out();
    end
  endtask
  // offset keeps link edges away from the clock edge
  task automatic m_addr(input logic [7:0] b);
    #7;
    u_mst.start();
    u_mst.xfer(b, 1'b1, q, ack);
  endtask
  initial begin
    void'($urandom(50363));
    own = 8'($urandom) & 8'h7f;
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rc("status", `ISA_OFF_STAT, stat_exp(0, 0, 0, 0, 1));
    apb(1'b0, 8'h18, 32'h0);
    check("slverr", 32'h1, {31'h0, er});
    apb(1'b1, `ISA_OFF_ADDR, {24'h0, own});
    rc("own_addr", `ISA_OFF_ADDR, {24'h0, own});
    apb(1'b1, `ISA_OFF_CTRL, 32'h02);
    m_addr({own[6:0], 1'b0});
    check("ack_off", 32'h1, {31'h0, ack});
    u_mst.stop();
    apb(1'b1, `ISA_OFF_CTRL, 32'hc2);
    m_addr({own[6:0] ^ 7'h01, 1'b0});
    check("ack_miss", 32'h1, {31'h0, ack});
    rc("busy", `ISA_OFF_STAT, stat_exp(0, 1, 0, 0, 1));
    #7;
    u_mst.stop();
    rc("idle", `ISA_OFF_STAT, stat_exp(0, 0, 0, 0, 1));
    check("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, `ISA_OFF_IRQM, 32'h7);
    wait_irq();
    rc("irq_stop", `ISA_OFF_IRQS, 32'h4);
    apb(1'b1, `ISA_OFF_IRQS, 32'h4);
    repeat (2) @(posedge clk);
    check("irq_clr", 32'h0, {31'h0, irq});
    lowpwr <= 1'b1;
    apb(1'b1, `ISA_OFF_STAT, 32'h02);
    fork
      begin
        m_addr({own[6:0], 1'b0});
        check("ack_addr", 32'h0, {31'h0, ack});
        u_mst.xfer(d0, 1'b1, q, ack);
        check("ack_data", 32'h0, {31'h0, ack});
        u_mst.stop();
      end
      begin
        wait_irq();
        check("wake", 32'h1, {31'h0, wake});
        rc("irq_addr", `ISA_OFF_IRQS, 32'h1);
        rc("matched", `ISA_OFF_STAT, stat_exp(1, 1, 0, 1, 1));
        apb(1'b1, `ISA_OFF_IRQS, 32'h1);
        apb(1'b0, `ISA_OFF_DATA, 32'h0);
        wait_irq();
        rc("irq_byte", `ISA_OFF_IRQS, 32'h2);
        rc("rx_byte", `ISA_OFF_DATA, {24'h0, d0});
        apb(1'b1, `ISA_OFF_IRQS, 32'h2);
      end
    join
    @(posedge clk);
    lowpwr <= 1'b0;
    apb(1'b1, `ISA_OFF_IRQS, 32'h4);
    check("wake_off", 32'h0, {31'h0, wake});
    fork
      begin
        m_addr({own[6:0], 1'b1});
        check("ack_rd", 32'h0, {31'h0, ack});
        u_mst.xfer(8'hff, 1'b0, q, ack);
        check("tx0", {24'h0, d0}, {24'h0, q});
        u_mst.xfer(8'hff, 1'b1, q, ack);
        check("tx1", {24'h0, d1}, {24'h0, q});
        #200;
        check("sda_free", 32'h0, {31'h0, sda_oe});
        u_mst.stop();
      end
      begin
        wait_irq();
        rc("read_req", `ISA_OFF_STAT, stat_exp(1, 1, 1, 1, 1));
        apb(1'b1, `ISA_OFF_IRQS, 32'h1);
        apb(1'b1, `ISA_OFF_STAT, 32'h10);
        apb(1'b1, `ISA_OFF_DATA, {24'h0, d0});
        wait_irq();
        apb(1'b0, `ISA_OFF_STAT, 32'h0);
        check("rx_ack0", 32'h0, {31'h0, rd[0]});
        apb(1'b1, `ISA_OFF_IRQS, 32'h2);
        apb(1'b1, `ISA_OFF_DATA, {24'h0, d1});
        wait_irq();
        apb(1'b0, `ISA_OFF_STAT, 32'h0);
        check("rx_ack1", 32'h1, {31'h0, rd[0]});
        apb(1'b1, `ISA_OFF_IRQS, 32'h2);
      end
    join
    check("link_hang", 32'h0, {31'h0, m_hung});
    close_out();
  end
endmodule
bind isa_slave isa_chk u_chk (.CLK_I(CLK_I), .SRST_I(SRST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SCL_I(SCL_I),
  .SCL_O(SCL_O), .SCL_OE_O(SCL_OE_O), .SDA_I(SDA_I), .SDA_O(SDA_O),
  .SDA_OE_O(SDA_OE_O), .LOWPWR_I(LOWPWR_I), .IRQ_O(IRQ_O),
  .WAKE_O(WAKE_O));
`default_nettype wire
